// ===== verif/cfx_can_model.sv
/*
 cfx_can_model: frame source in place of the can controller.
 assumes send is called just after a rising clk edge.
*/
`default_nettype none
module cfx_can_model
(
   // clock
   input wire logic clk,
   // frame link
   output logic rx_valid,
   output logic rx_ext,
   output logic [28:0] rx_id,
   output logic [63:0] rx_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      rx_valid = 1'b0;
      rx_ext = 1'b0;
      rx_id = 29'h0;
      rx_data = 64'h0;
   end
   // =====================================================
   // one frame
   // eight byte payload
   task automatic send(input logic ext, input logic [28:0] id,
      input logic [63:0] d);
      rx_valid <= 1'b1;
      rx_ext <= ext;
      rx_id <= id;
      rx_data <= d;
      @(posedge clk);
      // idle lines show junk so a stale frame never looks valid
      rx_valid <= 1'b0;
      rx_ext <= ~ext;
      rx_id <= ~id;
      rx_data <= ~d;
   endtask : send
endmodule : cfx_can_model
`default_nettype wire

// ===== verif/test_can_id_filter_signal_extractor.sv
/*
 test_can_id_filter_signal_extractor: self-checking bench of cfx_core.
 assumes a zero-wait ahb-lite slave and cfx_can_model beside it.
*/
`default_nettype none
module test_can_id_filter_signal_extractor;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] haddr = 8'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hready, hresp, rx_valid, rx_ext, sig_valid, tx_ext;
   logic [28:0] rx_id, tx_id;
   logic [63:0] rx_data, sig_value;
   logic [63:0] last = 64'h0;
   int n_errors = 0;
   int checks_done = 0;
   always #12.5 clk = ~clk;
   cfx_core i_cfx_core (.clk(clk), .sys_rst(sys_rst), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .rx_valid(rx_valid),
      .rx_ext(rx_ext), .rx_id(rx_id), .rx_data(rx_data),
      .sig_value(sig_value), .sig_valid(sig_valid), .tx_id(tx_id),
      .tx_ext(tx_ext));
   cfx_can_model i_cfx_can_model (.clk(clk), .rx_valid(rx_valid),
      .rx_ext(rx_ext), .rx_id(rx_id), .rx_data(rx_data));
   // =====================================================
   // shared tasks
   task automatic chk(input string what, input logic [63:0] seen,
      input logic [63:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'h2;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      // read data still stands here: the edge's register updates come later
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rdm(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e, input string what);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(what, 64'(q & m), 64'(e));
   endtask : rdm
   task automatic frm(input logic ext, input logic [28:0] id,
      input logic [63:0] d, input logic acc, input logic [63:0] v);
      i_cfx_can_model.send(ext, id, d);
      if (acc)
         last = v;
      @(negedge clk);
      chk("sig_valid", 64'(sig_valid), 64'(acc));
      chk("sig_value", sig_value, last);
      @(posedge clk);
      @(negedge clk);
      chk("sig_valid pulse", 64'(sig_valid), 64'h0);
      @(posedge clk);
   endtask : frm
   // =====================================================
   // scenarios
   // reset values
   task automatic t_reset;
      rdm(cfx_pkg::REG_ID, ALL, 32'h1, "id");
      rdm(cfx_pkg::REG_MASK, ALL, 32'h7FF, "mask");
      rdm(cfx_pkg::REG_SIG, ALL, 32'h800, "sig");
      rdm(cfx_pkg::REG_TXID, ALL, 32'h1, "txid");
      rdm(8'h20, ALL, 32'h0, "unmapped");
      $display("t_reset done");
   endtask : t_reset
   task automatic t_ident;
      wr(cfx_pkg::REG_ID, 32'h0);
      rdm(cfx_pkg::REG_ID, ALL, 32'h1, "id zero");
      rdm(cfx_pkg::REG_STAT, 32'h1, 32'h1, "refused");
      chk("hresp", 64'(hresp), 64'h0);
      wr(cfx_pkg::REG_ID, 32'h800);
      rdm(cfx_pkg::REG_ID, ALL, 32'h1, "id 800");
      wr(cfx_pkg::REG_ID, 32'h7FF);
      rdm(cfx_pkg::REG_STAT, 32'h1, 32'h0, "accepted");
      chk("tx_id", 64'(tx_id), 64'h7FF);
      wr(cfx_pkg::REG_CTRL, 32'h2);
      wr(cfx_pkg::REG_ID, 32'h1FFF_FFFF);
      rdm(cfx_pkg::REG_ID, ALL, 32'h7FF, "no ext");
      chk("tx_ext", 64'(tx_ext), 64'h0);
      wr(cfx_pkg::REG_CTRL, 32'h3);
      wr(cfx_pkg::REG_ID, 32'h1FFF_FFFF);
      rdm(cfx_pkg::REG_ID, ALL, 32'h1FFF_FFFF, "id ext");
      chk("tx_ext", 64'(tx_ext), 64'h1);
      wr(cfx_pkg::REG_MASK, 32'h1FFF_FFFF);
      rdm(cfx_pkg::REG_MASK, ALL, 32'h1FFF_FFFF, "mask29");
      frm(1'b1, 29'h1FFF_FFFF, 64'h3, 1'b1, 64'h3);
      wr(cfx_pkg::REG_CTRL, 32'h0);
      wr(cfx_pkg::REG_MASK, 32'h1FFF_FFFF);
      rdm(cfx_pkg::REG_MASK, ALL, 32'h7FF, "mask11");
      $display("t_ident done");
   endtask : t_ident
   task automatic t_filter;
      logic [10:0] ids [7];
      logic [6:0] acc;
      ids = '{11'h024, 11'h025, 11'h026, 11'h027, 11'h023, 11'h007,
         11'h427};
      acc = 7'h4F;
      wr(cfx_pkg::REG_ID, 32'h27);
      wr(cfx_pkg::REG_MASK, 32'h24);
      for (int i = 0; i < 7; i++)
         frm(1'b0, 29'(ids[i]), 64'(i + 1), acc[i], 64'(i + 1));
      frm(1'b1, 29'h27, 64'h55, 1'b0, 64'h0);
      wr(cfx_pkg::REG_MASK, 32'h7FF);
      frm(1'b0, 29'h26, 64'h66, 1'b0, 64'h0);
      frm(1'b0, 29'h27, 64'h9, 1'b1, 64'h9);
      $display("t_filter done");
   endtask : t_filter
   task automatic t_extract;
      logic [31:0] w [13];
      logic [63:0] e [13];
      w = '{32'h4_0807, 32'h807, 32'h1052, 32'h8_1002, 32'h2001,
         32'h10_2001, 32'h18_2001, 32'h8_2001, 32'h6_0177,
         32'h2_0116, 32'h19_2004, 32'h1_4000, 32'h1007};
      e = '{64'hFFFF_FFFF_FFFF_FF80, 64'h80, 64'h2345, 64'h4523,
         64'h123_4567, 64'h4567_0123, 64'h6745_2301, 64'h2301_6745,
         64'h1, 64'h0, 64'hFFFF_FFFF_80CD_EF67,
         64'h1_2345_67EF_CD80, 64'hCD80};
      for (int i = 0; i < 13; i++)
      begin
         wr(cfx_pkg::REG_SIG, w[i]);
         frm(1'b0, 29'h27, 64'h80CD_EF67_4523_0100, 1'b1, e[i]);
      end
      rdm(cfx_pkg::REG_VLO, ALL, 32'h0000_CD80, "value low");
      rdm(cfx_pkg::REG_VHI, ALL, 32'h0, "value high");
      rdm(cfx_pkg::REG_SIG, 32'h7, 32'h6, "byte off clamp");
      rdm(cfx_pkg::REG_STAT, 32'h3FE, 32'h52, "stat");
      wr(cfx_pkg::REG_SIG, 32'h3);
      rdm(cfx_pkg::REG_SIG, 32'h7F07, 32'h4000, "len zero");
      $display("t_extract done");
   endtask : t_extract
   // =====================================================
   // run control
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude
   initial
   begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_ident;
      t_filter;
      t_extract;
      conclude;
   end
   // the whole run is well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge clk);
      n_errors++;
      conclude;
   end
endmodule : test_can_id_filter_signal_extractor
`default_nettype wire

// ===== verilog/cfx_core.sv
/*
 cfx_core: one can channel behind a frame-level controller: id mask
 filter, signal extraction, transmit id, ahb-lite register slave.
 assumes frames arrive as single-cycle strobes on the clk domain.
*/
// The AHB-Lite slave port and the register addresses are this design's own decisions.
// Summary of operation
// R01: channel id nonzero and within 0x7FF or 0x1FFFFFFF, else rejected
// R02: per channel format selects 11 or 29 bit identifier
// R03: 29-bit format only when extended ids enabled for connection
// R04: accept when received id and mask equals configured id and mask
// R05: zero mask bits are don't-care, accepting identifier groups
// R06: all-ones mask accepts only the exact configured id
// R07: mask width follows selected format, 11 or 29 bits
// R08: payload holds up to eight bytes carrying several signals
// R09: byte offset defaults 0, max is payload size minus signal bytes
// R10: bit offset 0 to 7 for single-bit signals only, default 0
// R11: integers signed two's complement or unsigned by option
// R12: floats always signed, bit signals ignore signed option
// R13: field width is configurable bit length up to 64 bits
// R14: msb first order takes top byte from lowest payload position
// R15: lsb first order takes low byte from lowest payload position
// R16: word order arranges 16-bit words independently of byte order
// R17: configured id is the identifier of transmitted frames
// R18: accepted frame gives value and one-cycle valid; rejects change nothing
`default_nettype none
module cfx_core
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // received frames from controller
   input wire logic rx_valid,
   input wire logic rx_ext,
   input wire logic [28:0] rx_id,
   input wire logic [63:0] rx_data,
   // extracted signal
   output logic [63:0] sig_value,
   output logic sig_valid,
   // transmit identifier
   output logic [28:0] tx_id,
   output logic tx_ext
);
   // =====================================================
   // registers
   logic ext_en_r;
   logic fmt29_r;
   logic [28:0] id_r;
   logic [28:0] mask_r;
   logic [2:0] byte_off_r;
   logic [2:0] bit_off_r;
   logic [6:0] len_r;
   logic [1:0] dtype_r;
   logic signed_r;
   logic lsb_first_r;
   logic word_lsb_r;
   logic id_err_r;
   logic off_err_r;
   logic [63:0] value_r;
   logic valid_r;
   logic [7:0] frames_r;
   logic ph_wr_r;
   logic ph_rd_r;
   logic [7:0] ph_addr_r;

   logic fmt29;
   logic [28:0] id_max;
   logic [28:0] fmt_mask;
   logic [28:0] wid;
   logic id_ok;
   logic [3:0] sig_bytes;
   logic [3:0] off_max;
   logic [2:0] wbyte;
   logic [6:0] wlen;
   logic [6:0] wlen_eff;
   logic [1:0] wtype;
   logic match;
   logic [63:0] ext_value;
   logic addr_ok;

   // =====================================================
   // format and limits
   // R03 29-bit needs connection enable
   assign fmt29 = fmt29_r & ext_en_r;
   // R02 R07 width of id and mask
   assign id_max = fmt29 ? cfx_pkg::ID_MAX_EXT : cfx_pkg::ID_MAX_STD;
   assign fmt_mask = id_max;
   // R01 id range check on write
   assign wid = hwdata[28:0];
   assign id_ok = (wid != 29'h0) && (wid <= id_max);
   // R09 offset limit from signal byte length
   assign wlen = hwdata[cfx_pkg::SIG_LEN_LSB +: 7];
   assign wtype = hwdata[cfx_pkg::SIG_TYPE_LSB +: 2];
   assign wbyte = hwdata[cfx_pkg::SIG_BYTE_LSB +: 3];
   // limit from the length actually stored, so a zero or oversize length
   // cannot open the offset range
   assign wlen_eff = (wlen > cfx_pkg::LEN_MAX || wlen == 7'h0)
                     ? cfx_pkg::LEN_MAX : wlen;
   assign sig_bytes = (wtype == cfx_pkg::DT_BIT) ? 4'd1
                      : 4'((wlen_eff + 7'd7) >> 3);
   assign off_max = 4'(cfx_pkg::PAYLOAD_BYTES) - sig_bytes;
   assign addr_ok = (ph_addr_r[1:0] == 2'b00)
                    && (ph_addr_r <= cfx_pkg::REG_TXID);

   // =====================================================
   // ahb-lite address phase
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ph_wr_r <= 1'b0;
         ph_rd_r <= 1'b0;
         ph_addr_r <= 8'h00;
      end
      else if (hready)
      begin
         ph_wr_r <= hsel & htrans[1] & hwrite;
         ph_rd_r <= hsel & htrans[1] & ~hwrite;
         ph_addr_r <= haddr;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // zero-wait read: data driven while the data phase stands
   always_comb
   begin
      hrdata = cfx_pkg::AHB_RESP_ZERO;
      if (ph_rd_r && addr_ok)
      begin
         unique case (ph_addr_r)
            cfx_pkg::REG_CTRL: hrdata = {30'h0, fmt29_r, ext_en_r};
            cfx_pkg::REG_ID: hrdata = {3'h0, id_r};
            cfx_pkg::REG_MASK: hrdata = {3'h0, mask_r};
            cfx_pkg::REG_SIG:
               hrdata = {11'h0, word_lsb_r, lsb_first_r, signed_r,
                         dtype_r, 1'b0, len_r, 1'b0, bit_off_r,
                         1'b0, byte_off_r};
            cfx_pkg::REG_STAT: hrdata = {22'h0, frames_r, off_err_r,
                                         id_err_r};
            cfx_pkg::REG_VLO: hrdata = value_r[31:0];
            cfx_pkg::REG_VHI: hrdata = value_r[63:32];
            cfx_pkg::REG_TXID: hrdata = {2'h0, tx_ext, tx_id};
            default: hrdata = cfx_pkg::AHB_RESP_ZERO;
         endcase
      end
   end

   // =====================================================
   // configuration writes
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ext_en_r <= 1'b0;
         fmt29_r <= 1'b0;
      end
      else if (ph_wr_r && ph_addr_r == cfx_pkg::REG_CTRL)
      begin
         ext_en_r <= hwdata[cfx_pkg::CTRL_EXT_EN];
         fmt29_r <= hwdata[cfx_pkg::CTRL_FMT29];
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         id_r <= cfx_pkg::ID_RST;
         id_err_r <= 1'b0;
      end
      else if (ph_wr_r && ph_addr_r == cfx_pkg::REG_ID)
      begin
         // R01 out of range id is refused
         if (id_ok)
            id_r <= wid;
         id_err_r <= ~id_ok;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         mask_r <= cfx_pkg::MASK_RST;
      // R07 mask cut to format width
      else if (ph_wr_r && ph_addr_r == cfx_pkg::REG_MASK)
         mask_r <= hwdata[28:0] & fmt_mask;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         byte_off_r <= 3'h0;
         bit_off_r <= 3'h0;
         len_r <= cfx_pkg::LEN_RST;
         dtype_r <= cfx_pkg::DT_INT;
         signed_r <= 1'b0;
         lsb_first_r <= 1'b0;
         word_lsb_r <= 1'b0;
         off_err_r <= 1'b0;
      end
      else if (ph_wr_r && ph_addr_r == cfx_pkg::REG_SIG)
      begin
         // R13 length capped at a full payload
         len_r <= wlen_eff;
         dtype_r <= wtype;
         signed_r <= hwdata[cfx_pkg::SIG_SIGNED];
         lsb_first_r <= hwdata[cfx_pkg::SIG_LSB_FIRST];
         word_lsb_r <= hwdata[cfx_pkg::SIG_WORD_LSB_FIRST];
         // R10 bit offset kept only for bit type
         bit_off_r <= (wtype == cfx_pkg::DT_BIT)
                      ? hwdata[cfx_pkg::SIG_BIT_LSB +: 3] : 3'h0;
         // R09 offset clamped to what fits
         if ({1'b0, wbyte} > off_max)
         begin
            byte_off_r <= off_max[2:0];
            off_err_r <= 1'b1;
         end
         else
         begin
            byte_off_r <= wbyte;
            off_err_r <= 1'b0;
         end
      end
   end

   // =====================================================
   // acceptance filter
   // R04 R05 R06 masked compare, format must agree
   assign match = rx_valid && (rx_ext == fmt29)
                  && (((rx_id & fmt_mask) & mask_r)
                      == (id_r & mask_r));

   // R08 payload up to eight bytes, one signal per channel
   cfx_extract u_extract
   (
      .payload(rx_data),
      .byte_off(byte_off_r),
      .bit_off(bit_off_r),
      .bit_len(len_r),
      .dtype(dtype_r),
      .is_signed(signed_r),
      .lsb_first_order(lsb_first_r),
      .word_lsb_first(word_lsb_r),
      .value(ext_value)
   );

   // R18 capture only accepted frames
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         value_r <= 64'h0000_0000_0000_0000;
         valid_r <= 1'b0;
         frames_r <= 8'h00;
      end
      else
      begin
         valid_r <= match;
         if (match)
         begin
            value_r <= ext_value;
            frames_r <= frames_r + 8'h01;
         end
      end
   end

   assign sig_value = value_r;
   assign sig_valid = valid_r;
   // R17 transmit frames use configured id
   assign tx_id = id_r;
   assign tx_ext = fmt29;

   // =====================================================
   // checks
   a_accept_strobe: assert property (@(posedge clk) disable iff (sys_rst)
      match |=> sig_valid && sig_value == $past(ext_value)) // R18
      else $error("accepted frame not presented");
   a_reject_hold: assert property (@(posedge clk) disable iff (sys_rst)
      !match |=> !sig_valid && $stable(sig_value)) // R04
      else $error("rejected frame changed output");
   a_id_range: assert property (@(posedge clk) disable iff (sys_rst)
      id_r != 29'h0 && id_r <= cfx_pkg::ID_MAX_EXT) // R01
      else $error("identifier out of range");
   a_fmt_gate: assert property (@(posedge clk) disable iff (sys_rst)
      !ext_en_r |-> !tx_ext) // R03
      else $error("29-bit format without enable");
   a_exact_id: assert property (@(posedge clk) disable iff (sys_rst)
      (mask_r == fmt_mask && match) |-> (rx_id & fmt_mask) == id_r) // R06
      else $error("full mask accepted other id");
   a_mask_width: assert property (@(posedge clk) disable iff (sys_rst)
      !fmt29 && $past(ph_wr_r) |-> (mask_r & ~cfx_pkg::ID_MAX_STD) == 29'h0
      || $past(ph_addr_r) != cfx_pkg::REG_MASK) // R07
      else $error("mask wider than format");
   a_offset_fit: assert property (@(posedge clk) disable iff (sys_rst)
      dtype_r == cfx_pkg::DT_INT |->
      4'(byte_off_r) + 4'((len_r + 7'd7) >> 3) <= 4'd8 || off_err_r) // R09
      else $error("signal runs past payload");
   a_bit_offset: assert property (@(posedge clk) disable iff (sys_rst)
      dtype_r != cfx_pkg::DT_BIT |-> bit_off_r == 3'h0) // R10
      else $error("bit offset on non-bit type");
   a_bit_value: assert property (@(posedge clk) disable iff (sys_rst)
      match && dtype_r == cfx_pkg::DT_BIT |=> sig_value[63:1] == 63'h0) // R12
      else $error("bit signal sign extended");
   a_tx_follow: assert property (@(posedge clk) disable iff (sys_rst)
      tx_id == id_r) // R17
      else $error("tx id differs from channel id");
endmodule : cfx_core
`default_nettype wire

// ===== verilog/cfx_extract.sv
/*
 cfx_extract: combinational signal extractor from an 8-byte payload.
 assumes payload byte 0 sits in bits 7:0 and the config is stable.
*/
`default_nettype none
module cfx_extract
(
   // payload and layout
   input wire logic [63:0] payload,
   input wire logic [2:0] byte_off,
   input wire logic [2:0] bit_off,
   input wire logic [6:0] bit_len,
   input wire logic [1:0] dtype,
   input wire logic is_signed,
   input wire logic lsb_first_order,
   input wire logic word_lsb_first,
   // result
   output logic [63:0] value
);
   logic [63:0] shifted;
   logic [63:0] ordered;
   logic [63:0] masked;
   logic [3:0] nbytes;
   logic [3:0] nwords;
   logic [63:0] sel;
   logic [15:0] w;
   logic sgn;
   int j;
   int k;

   always_comb
   begin
      w = 16'h0000;
      shifted = payload >> {byte_off, 3'b000};
      nbytes = 4'((bit_len + 7'd7) >> 3);
      nwords = 4'((nbytes + 4'd1) >> 1);
      ordered = 64'h0000_0000_0000_0000;
      // R14 msb first bytes
      // R15 lsb first bytes
      for (j = 0; j < 8; j++)
      begin
         if (4'(j) < nbytes)
         begin
            if (lsb_first_order)
               ordered[8*j +: 8] = shifted[8*j +: 8];
            else
               ordered[8*j +: 8] = shifted[8*(32'(nbytes)-1-j) +: 8];
         end
      end
      // R16 word order swap
      sel = ordered;
      if (!word_lsb_first && lsb_first_order && nwords > 4'd1)
      begin
         for (k = 0; k < 4; k++)
         begin
            w = ordered[16*k +: 16];
            if (4'(k) < nwords)
               sel[16*(32'(nwords)-1-k) +: 16] = w;
         end
      end
      else if (word_lsb_first && !lsb_first_order && nwords > 4'd1)
      begin
         for (k = 0; k < 4; k++)
         begin
            w = ordered[16*k +: 16];
            if (4'(k) < nwords)
               sel[16*(32'(nwords)-1-k) +: 16] = w;
         end
      end
      // R13 field width
      if (bit_len >= 7'd64)
         masked = sel;
      else
         masked = sel & ~(64'hFFFF_FFFF_FFFF_FFFF << bit_len);
      sgn = (bit_len == 7'd0) ? 1'b0 : masked[6'(bit_len - 7'd1)];
      value = masked;
      // R10 single bit select
      if (dtype == cfx_pkg::DT_BIT)
         value = {63'h0, shifted[bit_off]};
      // R11 R12 sign handling
      else if ((dtype == cfx_pkg::DT_FLOAT || is_signed) && sgn
               && bit_len < 7'd64)
         value = masked | (64'hFFFF_FFFF_FFFF_FFFF << bit_len);
   end
endmodule : cfx_extract
`default_nettype wire

// ===== verilog/cfx_pkg.sv
/*
 package for the can id filter and signal extractor: register map,
 field layout, reset values and encodings.
 assumes a 32-bit ahb-lite slave and one 40 mhz clock.
*/
`default_nettype none
package cfx_pkg;
   // =====================================================
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ID = 8'h04;
   localparam logic [7:0] REG_MASK = 8'h08;
   localparam logic [7:0] REG_SIG = 8'h0C;
   localparam logic [7:0] REG_STAT = 8'h10;
   localparam logic [7:0] REG_VLO = 8'h14;
   localparam logic [7:0] REG_VHI = 8'h18;
   localparam logic [7:0] REG_TXID = 8'h1C;
   // =====================================================
   // ctrl fields
   localparam int CTRL_EXT_EN = 0;
   localparam int CTRL_FMT29 = 1;
   // sig fields
   localparam int SIG_BYTE_LSB = 0;
   localparam int SIG_BIT_LSB = 4;
   localparam int SIG_LEN_LSB = 8;
   localparam int SIG_TYPE_LSB = 16;
   localparam int SIG_SIGNED = 18;
   localparam int SIG_LSB_FIRST = 19;
   localparam int SIG_WORD_LSB_FIRST = 20;
   // =====================================================
   // limits and reset values
   localparam logic [28:0] ID_MAX_STD = 29'h0000_07FF;
   localparam logic [28:0] ID_MAX_EXT = 29'h1FFF_FFFF;
   localparam logic [28:0] ID_RST = 29'h0000_0001;
   localparam logic [28:0] MASK_RST = 29'h0000_07FF;
   localparam logic [6:0] LEN_RST = 7'h08;
   localparam logic [6:0] LEN_MAX = 7'h40;
   localparam int PAYLOAD_BYTES = 8;
   localparam logic [31:0] AHB_RESP_ZERO = 32'h0000_0000;
   // data type encodings
   localparam logic [1:0] DT_INT = 2'h0;
   localparam logic [1:0] DT_FLOAT = 2'h1;
   localparam logic [1:0] DT_BIT = 2'h2;
endpackage : cfx_pkg
`default_nettype wire
